/* crs_consts.svh */
/*
  constants for the processor sideband control block: register offsets,
  field positions, reset values and timing figures.
  assumes: included by bare name after the package.
*/
`ifndef CRS_CONSTS_SVH
`define CRS_CONSTS_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define CRS_CLK_KHZ        10000
`define CRS_POR_MIN_MS     1
`define CRS_RST_MAX_MS     10
`define CRS_SELFTEST_CYC   16
`define CRS_ECHO_GUARD     3

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define CRS_ADDR_W         8
`define CRS_DATA_W         32
`define CRS_CFG_W          8
`define CRS_CNT_W          17
`define CRS_EVT_W          8

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define CRS_REG_CTRL       8'h00
`define CRS_REG_STATUS     8'h04
`define CRS_REG_MASK       8'h08
`define CRS_REG_CONFIG     8'h0C
`define CRS_REG_STATE      8'h10

// ----------------------------------------------------------------------
// control fields and reset value
// ----------------------------------------------------------------------
`define CRS_CTRL_TCC_EN    0
`define CRS_CTRL_RESUME    1
`define CRS_CTRL_RST       1'h1

// ----------------------------------------------------------------------
// status and mask fields
// ----------------------------------------------------------------------
`define CRS_EV_HOT         0
`define CRS_EV_EXT_HOT     1
`define CRS_EV_MGMT        2
`define CRS_EV_RESET       3
`define CRS_EV_SELFTEST    4
`define CRS_EV_HIZ         5
`define CRS_EV_RST_LONG    6
`define CRS_EV_POR_SHORT   7
`define CRS_MASK_RST       8'h00

`endif

/* crs_pkg.sv */
/*
  types for the processor sideband control block.
  assumes: nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package crs_pkg;

  // ----------------------------------------------------------------------
  // sequencer states, gray along the power-up path through self test
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    CRS_OFF      = 3'h0,
    CRS_RESET    = 3'h1,
    CRS_CAPTURE  = 3'h3,
    CRS_SELFTEST = 3'h2,
    CRS_RUN      = 3'h6,
    CRS_MGMT_ACK = 3'h7,
    CRS_MGMT     = 3'h5,
    CRS_HIZ      = 3'h4
  } crs_state_t;

endpackage

`default_nettype wire

/* crs_sync_if.sv */
/*
  interface carrying the raw and synchronised sideband inputs.
  assumes: one clock domain, ref_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none

interface crs_sync_if;
  logic thermal_raw_n;
  logic mgmt_raw_n;
  logic thermal_sync_n;
  logic mgmt_sync_n;

  modport sync (
    input  thermal_raw_n,
    input  mgmt_raw_n,
    output thermal_sync_n,
    output mgmt_sync_n
  );

  modport user (
    output thermal_raw_n,
    output mgmt_raw_n,
    input  thermal_sync_n,
    input  mgmt_sync_n
  );
endinterface

`default_nettype wire

/* crs_sync.sv */
/*
  two-stage synchronisers for the asynchronous sideband inputs.
  assumes: inputs idle high; synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

module crs_sync
  import crs_pkg::*;
(
  input  wire logic   ref_clk_i,
  input  wire logic   reset_i,
  crs_sync_if.sync    sig
);

  logic [1:0] meta_q;
  logic [1:0] stab_q;

  // ----------------------------------------------------------------------
  // first stage feeds only the second
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      meta_q <= 2'h3;
      stab_q <= 2'h3;
    end else begin
      meta_q <= {sig.mgmt_raw_n, sig.thermal_raw_n};
      stab_q <= meta_q;
    end
  end

  assign sig.thermal_sync_n = stab_q[0];
  assign sig.mgmt_sync_n    = stab_q[1];

endmodule

`default_nettype wire

/* crs_sideband_ctrl.sv */
/*
  processor sideband control: power-good qualification, reset sequence
  with configuration capture, management-mode entry, thermal alarm pin.
  assumes: one clock ref_clk_i at 10 MHz; register master per plain port;
  thermal alarm pin is open drain, resolved outside.
*/
// Our own choices: the plain strobed port and the register offsets.
// Summary of operation
// - drive thermal alarm when sensor reaches maximum
// - external thermal alarm activates enabled control circuit
// - control circuit stays active until alarm released
// - reset returns known state, caches dropped unwritten
// - bus outputs released within two clocks of reset
// - capture configuration at reset release
// - accepted management interrupt saves state, enters mode
// - acknowledge transaction first, then run handler
// - management interrupt at reset release tristates outputs
// - warm start at reset release runs self test
`timescale 1ns/1ps
`default_nettype none
`include "crs_consts.svh"

module crs_sideband_ctrl
  import crs_pkg::*;
#(
  parameter int POR_MIN_CYC = `CRS_POR_MIN_MS * `CRS_CLK_KHZ,
  parameter int RST_MAX_CYC = `CRS_RST_MAX_MS * `CRS_CLK_KHZ
) (
  input  wire logic                    ref_clk_i,
  input  wire logic                    reset_i,
  input  wire logic                    power_stable_i,
  input  wire logic                    bus_reset_n_i,
  input  wire logic                    warm_start_n_i,
  input  wire logic [`CRS_CFG_W-1:0]   cfg_bus_i,
  input  wire logic                    temp_at_max_i,
  input  wire logic                    thermal_alarm_n_i,
  output logic                         thermal_alarm_n_o,
  output logic                         thermal_alarm_n_oe_o,
  input  wire logic                    mgmt_interrupt_n_i,
  input  wire logic                    mgmt_ack_done_i,
  output logic                         tcc_active_o,
  output logic                         cache_invalidate_o,
  output logic                         core_reset_o,
  output logic                         bus_oe_o,
  output logic                         outputs_hiz_o,
  output logic [`CRS_CFG_W-1:0]        cfg_options_o,
  output logic                         self_test_run_o,
  output logic                         state_save_o,
  output logic                         mgmt_ack_req_o,
  output logic                         management_mode_o,
  output logic                         handler_run_o,
  input  wire logic [`CRS_ADDR_W-1:0]  reg_addr_i,
  input  wire logic [`CRS_DATA_W-1:0]  reg_wdata_i,
  input  wire logic                    reg_we_i,
  input  wire logic                    reg_re_i,
  output logic [`CRS_DATA_W-1:0]       reg_rdata_o,
  output logic                         irq_o
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic fell(input logic prev, input logic now);
    return prev & ~now;
  endfunction

  function automatic logic hit(input logic [`CRS_ADDR_W-1:0] a,
                               input logic [`CRS_ADDR_W-1:0] off);
    return a == off;
  endfunction

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  crs_sync_if sync_bus ();

  assign sync_bus.thermal_raw_n = thermal_alarm_n_i;
  assign sync_bus.mgmt_raw_n    = mgmt_interrupt_n_i;

  crs_sync u_sync (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .sig       (sync_bus.sync)
  );

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  crs_state_t               state_q;
  crs_state_t               state_d;
  logic                     tcc_en_q;
  logic [`CRS_EVT_W-1:0]    status_q;
  logic [`CRS_EVT_W-1:0]    status_d;
  logic [`CRS_EVT_W-1:0]    mask_q;
  logic [`CRS_EVT_W-1:0]    evt_set;
  logic [`CRS_CFG_W-1:0]    cfg_q;
  logic [`CRS_DATA_W-1:0]   rdata_q;
  logic [`CRS_DATA_W-1:0]   rdata_d;
  logic [`CRS_CNT_W-1:0]    rst_cnt_q;
  logic [4:0]               st_cnt_q;
  logic [`CRS_ECHO_GUARD-1:0] drive_hist_q;
  logic                     drive_q;
  logic                     ext_hot_q;
  logic                     hot_q;
  logic                     mgmt_prev_q;
  logic                     rst_prev_q;
  logic                     por_pend_q;
  logic                     long_flag_q;
  logic                     bus_oe_q;
  logic                     inval_q;
  logic                     save_q;

  wire rst_active    = ~bus_reset_n_i | ~power_stable_i;
  wire rst_release   = rst_prev_q & ~rst_active;
  wire mgmt_accept   = fell(mgmt_prev_q, sync_bus.mgmt_sync_n);
  wire mgmt_at_rel   = ~sync_bus.mgmt_sync_n;
  wire ext_hot       = ~sync_bus.thermal_sync_n & ~drive_q
                       & ~(|drive_hist_q);
  wire st_done       = st_cnt_q == 5'(`CRS_SELFTEST_CYC - 1);
  wire cnt_full      = rst_cnt_q == {`CRS_CNT_W{1'b1}};

  wire wr_ctrl       = reg_we_i & hit(reg_addr_i, `CRS_REG_CTRL);
  wire wr_status     = reg_we_i & hit(reg_addr_i, `CRS_REG_STATUS);
  wire wr_mask       = reg_we_i & hit(reg_addr_i, `CRS_REG_MASK);
  wire resume        = wr_ctrl & reg_wdata_i[`CRS_CTRL_RESUME];

  // ----------------------------------------------------------------------
  // thermal alarm pin and control circuit
  // ----------------------------------------------------------------------
  // pin driven low by the sensor; echoes of our own drive are masked
  assign thermal_alarm_n_o    = 1'b0;
  assign thermal_alarm_n_oe_o = drive_q;
  assign tcc_active_o         = tcc_en_q & (hot_q | ext_hot_q);

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      drive_q      <= 1'b0;
      drive_hist_q <= '0;
      hot_q        <= 1'b0;
      ext_hot_q    <= 1'b0;
    end else begin
      drive_q      <= temp_at_max_i & (state_q != CRS_HIZ);
      drive_hist_q <= {drive_hist_q[`CRS_ECHO_GUARD-2:0], drive_q};
      hot_q        <= temp_at_max_i;
      ext_hot_q    <= ext_hot;
    end
  end

  // ----------------------------------------------------------------------
  // reset sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      CRS_OFF: begin
        if (power_stable_i) begin
          state_d = CRS_RESET;
        end
      end
      CRS_RESET: begin
        if (rst_release) begin
          state_d = CRS_CAPTURE;
        end
      end
      CRS_CAPTURE: begin
        if (mgmt_at_rel) begin
          state_d = CRS_HIZ;
        end else if (~warm_start_n_i) begin
          state_d = CRS_SELFTEST;
        end else begin
          state_d = CRS_RUN;
        end
      end
      CRS_SELFTEST: begin
        if (st_done) begin
          state_d = CRS_RUN;
        end
      end
      CRS_RUN: begin
        if (mgmt_accept) begin
          state_d = CRS_MGMT_ACK;
        end
      end
      CRS_MGMT_ACK: begin
        if (mgmt_ack_done_i) begin
          state_d = CRS_MGMT;
        end
      end
      CRS_MGMT: begin
        if (resume) begin
          state_d = CRS_RUN;
        end
      end
      CRS_HIZ: begin
        state_d = CRS_HIZ;
      end
    endcase
    if (~power_stable_i) begin
      state_d = CRS_OFF;
    end else if (rst_active && state_q != CRS_OFF) begin
      state_d = CRS_RESET;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_q <= CRS_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      st_cnt_q <= '0;
    end else if (state_q == CRS_SELFTEST) begin
      st_cnt_q <= st_cnt_q + 5'h01;
    end else begin
      st_cnt_q <= '0;
    end
  end

  // ----------------------------------------------------------------------
  // reset edges, configuration capture, bus release
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rst_prev_q  <= 1'b0;
      mgmt_prev_q <= 1'b1;
      cfg_q       <= '0;
      bus_oe_q    <= 1'b0;
      inval_q     <= 1'b0;
      save_q      <= 1'b0;
    end else begin
      rst_prev_q  <= rst_active;
      mgmt_prev_q <= sync_bus.mgmt_sync_n;
      if (rst_release) begin
        cfg_q <= cfg_bus_i;
      end
      bus_oe_q    <= ~rst_active & (state_d != CRS_HIZ)
                     & (state_q != CRS_HIZ);
      inval_q     <= rst_active & ~rst_prev_q;
      save_q      <= (state_q == CRS_RUN) & mgmt_accept;
    end
  end

  assign core_reset_o       = state_q == CRS_OFF || state_q == CRS_RESET;
  assign cache_invalidate_o = inval_q;
  assign bus_oe_o           = bus_oe_q;
  assign outputs_hiz_o      = state_q == CRS_HIZ;
  assign cfg_options_o      = cfg_q;
  assign self_test_run_o    = state_q == CRS_SELFTEST;
  assign state_save_o       = save_q;
  assign mgmt_ack_req_o     = state_q == CRS_MGMT_ACK;
  assign management_mode_o  = state_q == CRS_MGMT_ACK
                              || state_q == CRS_MGMT;
  assign handler_run_o      = state_q == CRS_MGMT;

  // ----------------------------------------------------------------------
  // reset length monitor
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rst_cnt_q   <= '0;
      por_pend_q  <= 1'b0;
      long_flag_q <= 1'b0;
    end else begin
      if (~power_stable_i) begin
        rst_cnt_q  <= '0;
        por_pend_q <= 1'b1;
      end else if (~bus_reset_n_i) begin
        if (!cnt_full) begin
          rst_cnt_q <= rst_cnt_q + 17'h00001;
        end
      end else begin
        rst_cnt_q  <= '0;
        por_pend_q <= 1'b0;
      end
      long_flag_q <= ~bus_reset_n_i & power_stable_i
                     & (rst_cnt_q == `CRS_CNT_W'(RST_MAX_CYC));
    end
  end

  // ----------------------------------------------------------------------
  // events
  // ----------------------------------------------------------------------
  always_comb begin
    evt_set                     = '0;
    evt_set[`CRS_EV_HOT]        = temp_at_max_i & ~hot_q;
    evt_set[`CRS_EV_EXT_HOT]    = ext_hot & ~ext_hot_q;
    evt_set[`CRS_EV_MGMT]       = save_q;
    evt_set[`CRS_EV_RESET]      = inval_q;
    evt_set[`CRS_EV_SELFTEST]   = (state_q == CRS_SELFTEST) & st_done;
    evt_set[`CRS_EV_HIZ]        = (state_q == CRS_CAPTURE) & mgmt_at_rel;
    evt_set[`CRS_EV_RST_LONG]   = long_flag_q;
    evt_set[`CRS_EV_POR_SHORT]  = rst_release & por_pend_q & power_stable_i
                                  & (rst_cnt_q < `CRS_CNT_W'(POR_MIN_CYC));
  end

  // set wins over a same-cycle write-one clear
  assign status_d = (status_q
                     & ~(wr_status ? reg_wdata_i[`CRS_EVT_W-1:0] : '0))
                    | evt_set;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tcc_en_q <= `CRS_CTRL_RST;
      status_q <= '0;
      mask_q   <= `CRS_MASK_RST;
      rdata_q  <= '0;
    end else begin
      if (wr_ctrl) begin
        tcc_en_q <= reg_wdata_i[`CRS_CTRL_TCC_EN];
      end
      if (wr_mask) begin
        mask_q <= reg_wdata_i[`CRS_EVT_W-1:0];
      end
      status_q <= status_d;
      rdata_q  <= rdata_d;
    end
  end

  always_comb begin
    rdata_d = '0;
    if (reg_re_i) begin
      unique case (reg_addr_i)
        `CRS_REG_CTRL:   rdata_d[`CRS_CTRL_TCC_EN] = tcc_en_q;
        `CRS_REG_STATUS: rdata_d[`CRS_EVT_W-1:0] = status_q;
        `CRS_REG_MASK:   rdata_d[`CRS_EVT_W-1:0] = mask_q;
        `CRS_REG_CONFIG: rdata_d[`CRS_CFG_W-1:0] = cfg_q;
        `CRS_REG_STATE:  rdata_d[7:0] = {tcc_active_o, ext_hot_q,
                                         power_stable_i, rst_active,
                                         1'b0, state_q};
        default:         rdata_d = '0;
      endcase
    end
  end

  assign reg_rdata_o = rdata_q;
  assign irq_o       = |(status_q & mask_q);

endmodule

`default_nettype wire

/* crs_sideband_ctrl_assertions.sv */
/*
  port checker for the sideband control block.
  assumes: bound to crs_sideband_ctrl; one clock, synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "crs_consts.svh"

module crs_sideband_ctrl_assertions (
  input wire logic                  ref_clk_i,
  input wire logic                  reset_i,
  input wire logic                  power_stable_i,
  input wire logic                  bus_reset_n_i,
  input wire logic                  warm_start_n_i,
  input wire logic [`CRS_CFG_W-1:0] cfg_bus_i,
  input wire logic                  temp_at_max_i,
  input wire logic                  mgmt_ack_done_i,
  input wire logic                  thermal_alarm_n_o,
  input wire logic                  thermal_alarm_n_oe_o,
  input wire logic                  cache_invalidate_o,
  input wire logic                  core_reset_o,
  input wire logic                  bus_oe_o,
  input wire logic                  outputs_hiz_o,
  input wire logic [`CRS_CFG_W-1:0] cfg_options_o,
  input wire logic                  self_test_run_o,
  input wire logic                  state_save_o,
  input wire logic                  mgmt_ack_req_o,
  input wire logic                  management_mode_o,
  input wire logic                  handler_run_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  // ----------------------------------------
  // thermal pin, reset, mode entry
  // ----------------------------------------
  AST_ALARM_LOW: assert property (
    thermal_alarm_n_o == 1'h0) else $error("alarm drive not low");
  AST_ALARM_FOLLOW: assert property (
    !outputs_hiz_o && $past(!outputs_hiz_o) && $past(!reset_i)
    |-> thermal_alarm_n_oe_o == $past(temp_at_max_i))
    else $error("alarm drive not following sensor");
  AST_CACHE_DROP: assert property (
    $fell(bus_reset_n_i) && power_stable_i && !core_reset_o
    |-> ##[1:2] cache_invalidate_o) else $error("no cache drop");
  AST_KNOWN_STATE: assert property (
    core_reset_o |-> !management_mode_o && !self_test_run_o && !bus_oe_o)
    else $error("activity while in reset");
  AST_BUS_RELEASE: assert property (
    !bus_reset_n_i ##1 !bus_reset_n_i |-> !bus_oe_o)
    else $error("bus outputs held in reset");
  AST_CFG_CAPTURE: assert property (
    $fell(core_reset_o) |-> cfg_options_o == $past(cfg_bus_i))
    else $error("configuration not captured");
  AST_SAVE_ENTER: assert property (
    $rose(mgmt_ack_req_o) |-> state_save_o && management_mode_o
    && !handler_run_o) else $error("mode entry without save");
  AST_ACK_FIRST: assert property (
    $rose(handler_run_o) |-> $past(mgmt_ack_req_o))
    else $error("handler before acknowledge");
  AST_ACK_THEN_RUN: assert property (
    mgmt_ack_req_o && mgmt_ack_done_i && bus_reset_n_i && power_stable_i
    |=> handler_run_o && !mgmt_ack_req_o) else $error("handler not run");
  AST_HIZ_QUIET: assert property (
    outputs_hiz_o |-> !bus_oe_o && !thermal_alarm_n_oe_o && !handler_run_o)
    else $error("driving while tristated");
  AST_SELFTEST_START: assert property (
    $fell(core_reset_o) && !warm_start_n_i |-> ##[0:2] self_test_run_o)
    else $error("self test not started");
  AST_SELFTEST_HOLD: assert property (
    $rose(self_test_run_o) |-> (self_test_run_o || !bus_reset_n_i) [*8])
    else $error("self test cut short");
endmodule

bind crs_sideband_ctrl crs_sideband_ctrl_assertions chk (.*);

`default_nettype wire

/* crs_board_model.sv */
/*
  board side: power good, bus reset, acknowledge completion, alarm wire.
  assumes: alarm wire open drain with pull-up; one clock.
*/
`timescale 1ns/1ps
`default_nettype none

module crs_board_model (
  input  wire logic ref_clk_i,
  input  wire logic alarm_oe_i,
  input  wire logic ack_req_i,
  input  wire logic board_hot_i,
  input  wire logic slow_i,
  output logic      alarm_pin_n_o,
  output logic      power_stable_o,
  output logic      bus_reset_n_o,
  output logic      ack_done_o
);
  int wait_q = 0;

  // wired low by either party, else pulled up
  assign alarm_pin_n_o = !(alarm_oe_i === 1'h1 || board_hot_i);

  initial begin
    power_stable_o = 1'h0;
    bus_reset_n_o = 1'h0;
    ack_done_o = 1'h0;
  end

  // acknowledge finishes promptly or after a stall
  always @(posedge ref_clk_i) begin
    wait_q <= (ack_req_i === 1'h1) ? wait_q + 1 : 0;
    ack_done_o <= ack_req_i === 1'h1 && !ack_done_o
                  && wait_q >= (slow_i ? 6 : 0);
  end

  task automatic reset_cycle(input bit cold, input int hold);
    @(posedge ref_clk_i);
    bus_reset_n_o <= 1'h0;
    if (cold) begin
      power_stable_o <= 1'h0;
      repeat (4) @(posedge ref_clk_i);
      power_stable_o <= 1'h1;
    end
    repeat (hold) @(posedge ref_clk_i);
    bus_reset_n_o <= 1'h1;
  endtask
endmodule

`default_nettype wire

/* crs_sideband_ctrl_bench.sv */
/*
  self-checking bench for the sideband control block.
  assumes: board model at the far side, checker bound to dut.
*/
`timescale 1ns/1ps
`default_nettype none
`include "crs_consts.svh"

module crs_sideband_ctrl_bench;
  logic ref_clk_i, reset_i, power_stable_i, bus_reset_n_i, warm_start_n_i;
  logic temp_at_max_i, thermal_alarm_n_i, mgmt_interrupt_n_i, irq_o;
  logic mgmt_ack_done_i, reg_we_i, reg_re_i, board_hot, slow;
  logic thermal_alarm_n_o, thermal_alarm_n_oe_o, tcc_active_o;
  logic cache_invalidate_o, core_reset_o, bus_oe_o, outputs_hiz_o;
  logic self_test_run_o, state_save_o, mgmt_ack_req_o;
  logic management_mode_o, handler_run_o;
  logic [7:0]  cfg_bus_i, reg_addr_i, cfg_options_o;
  logic [31:0] reg_wdata_i, reg_rdata_o, rng;
  int          mismatches, num_checks, exp_st, n, st_cyc;

  crs_sideband_ctrl #(.POR_MIN_CYC(20), .RST_MAX_CYC(50)) dut (.*);
  crs_board_model board (
    .ref_clk_i(ref_clk_i), .alarm_oe_i(thermal_alarm_n_oe_o),
    .ack_req_i(mgmt_ack_req_o), .board_hot_i(board_hot), .slow_i(slow),
    .alarm_pin_n_o(thermal_alarm_n_i), .power_stable_o(power_stable_i),
    .bus_reset_n_o(bus_reset_n_i), .ack_done_o(mgmt_ack_done_i));

  initial begin
    ref_clk_i = 1'h0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  always @(negedge ref_clk_i) if (self_test_run_o === 1'h1) st_cyc++;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(negedge ref_clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'h1;
    @(posedge ref_clk_i);
    reg_we_i <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    reg_addr_i <= a;
    reg_re_i <= 1'h1;
    @(posedge ref_clk_i);
    reg_re_i <= 1'h0;
    @(negedge ref_clk_i);
    check(reg_rdata_o, e);
  endtask

  task automatic st_clear();
    rd(`CRS_REG_STATUS, exp_st);
    wr(`CRS_REG_STATUS, 32'hFF);
    exp_st = 0;
    step(1);
  endtask

  task automatic boot(input bit cold, input int hold, input bit warm);
    logic [7:0] cfg;
    cfg = xs();
    @(posedge ref_clk_i);
    cfg_bus_i <= cfg;
    warm_start_n_i <= !warm;
    board.reset_cycle(cold, hold);
    step(4);
    check(cfg_options_o, cfg);
    rd(`CRS_REG_CONFIG, cfg);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk_i);
    mismatches++;
    finish_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rng = 32'd23577;
    {reg_we_i, reg_re_i, temp_at_max_i, board_hot, slow} = 5'h00;
    {reg_addr_i, cfg_bus_i, reg_wdata_i} = 48'h0;
    {warm_start_n_i, mgmt_interrupt_n_i} = 2'h3;
    reset_i = 1'h1;
    repeat (8) @(posedge ref_clk_i);
    reset_i <= 1'h0;
    rd(`CRS_REG_CTRL, 32'h1);
    rd(`CRS_REG_MASK, 32'h0);
    rd(8'h14, 32'h0);
    boot(1, 5, 1);
    step(20);
    check(st_cyc, 32'h10);
    exp_st = 32'h98;
    st_clear();
    $display("cold boot done");
    boot(0, 60, 0);
    check(bus_oe_o, 32'h1);
    check(st_cyc, 32'h10);
    exp_st = 32'h48;
    st_clear();
    $display("warm boot done");
    @(posedge ref_clk_i);
    temp_at_max_i <= 1'h1;
    step(3);
    check(thermal_alarm_n_oe_o, 32'h1);
    check(tcc_active_o, 32'h1);
    @(posedge ref_clk_i);
    temp_at_max_i <= 1'h0;
    step(8);
    check(irq_o, 32'h0);
    exp_st = 32'h1;
    st_clear();
    for (int en = 1; en >= 0; en--) begin
      wr(`CRS_REG_CTRL, en);
      @(posedge ref_clk_i);
      board_hot <= 1'h1;
      step(30);
      check(tcc_active_o, en);
      @(posedge ref_clk_i);
      board_hot <= 1'h0;
      step(5);
      check(tcc_active_o, 32'h0);
    end
    exp_st = 32'h2;
    st_clear();
    wr(`CRS_REG_CTRL, 32'h1);
    $display("thermal done");
    wr(`CRS_REG_MASK, 32'h4);
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk_i);
      slow <= k[0];
      mgmt_interrupt_n_i <= 1'h0;
      for (n = 0; n < 10 && mgmt_ack_req_o !== 1'h1; n++) step(1);
      check(state_save_o, 32'h1);
      check(handler_run_o, 32'h0);
      @(posedge ref_clk_i);
      mgmt_interrupt_n_i <= 1'h1;
      for (n = 0; n < 20 && handler_run_o !== 1'h1; n++) step(1);
      check(management_mode_o, 32'h1);
      check(irq_o, 32'h1);
      exp_st = 32'h4;
      st_clear();
      check(irq_o, 32'h0);
      wr(`CRS_REG_CTRL, 32'h3);
      step(3);
      check(handler_run_o, 32'h0);
      rd(`CRS_REG_CTRL, 32'h1);
    end
    $display("management done");
    fork
      boot(0, 25, 0);
      begin
        repeat (5) @(posedge ref_clk_i);
        mgmt_interrupt_n_i <= 1'h0;
      end
    join
    check(outputs_hiz_o, 32'h1);
    check(bus_oe_o, 32'h0);
    @(posedge ref_clk_i);
    mgmt_interrupt_n_i <= 1'h1;
    exp_st = 32'h28;
    st_clear();
    $display("tristate done");
    finish_test();
  end
endmodule

`default_nettype wire
